/* File: core/hpc_pkg.sv */
// constants for the hub power, port numbering and fixed-device configuration bank
// assumes a 100 MHz core clock; offsets are the byte addresses of the config loader
package hpc_pkg;

  // ********************************************************************
  // register offsets
  // ********************************************************************
  localparam logic [7:0] PWR_DEV_CFG_OFS = 8'h07;
  localparam logic [7:0] PORT_NUM_CFG_OFS = 8'h08;
  localparam logic [7:0] FIXED_MASK_OFS = 8'h09;

  // ********************************************************************
  // field positions and writable masks
  // ********************************************************************
  localparam int AUTO_PWR_BIT = 7;
  localparam int OC_SEL_LSB = 4;
  localparam int COMPOUND_BIT = 3;
  localparam int PORT_NUM_SEL_BIT = 3;
  localparam int STRING_EN_BIT = 0;
  localparam int FIXED_PORT_LSB = 1;
  localparam logic [7:0] PWR_DEV_WR_MASK = 8'hb8;
  localparam logic [7:0] PORT_NUM_WR_MASK = 8'h09;
  localparam logic [7:0] FIXED_MASK_WR_MASK = 8'h1e;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [7:0] PWR_DEV_RST = 8'h00;
  localparam logic [7:0] PORT_NUM_RST = 8'h00;
  localparam logic [7:0] FIXED_MASK_RST = 8'h00;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OC_DELAY0_NS = 100000;
  localparam int unsigned OC_DELAY1_NS = 4000000;
  localparam int unsigned OC_DELAY2_NS = 8000000;
  localparam int unsigned OC_DELAY3_NS = 16000000;
  localparam int unsigned OC_CYC0 = OC_DELAY0_NS / CLK_PERIOD_NS;
  localparam int unsigned OC_CYC1 = OC_DELAY1_NS / CLK_PERIOD_NS;
  localparam int unsigned OC_CYC2 = OC_DELAY2_NS / CLK_PERIOD_NS;
  localparam int unsigned OC_CYC3 = OC_DELAY3_NS / CLK_PERIOD_NS;
  localparam int OC_CNT_W = 21;
  localparam logic [4:0] DROP_CYCLES = 5'h10;

  typedef enum logic [1:0]
  {
    ST_RUN = 2'b00,
    ST_DROP = 2'b01,
    ST_REATTACH = 2'b10
  } hpc_state_type;

endpackage

/* File: core/hpc_sync2.sv */
// two-flop synchroniser for levels arriving from pins
// assumes the level is quasi-static relative to core_clk
`timescale 1ns/100ps
`default_nettype none
module hpc_sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] metaReg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      metaReg <= '0;
      syncOut <= '0;
    end
    else if (clkEn)
    begin
      metaReg <= asyncIn;
      syncOut <= metaReg;
    end
  end

endmodule
`default_nettype wire

/* File: core/hpc_port_cfg_regs.sv */
// power switching, port numbering and fixed-device configuration bank
// assumes the config loader writes bytes on core_clk; supply and straps are pins
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - auto power bit 1 lets hub switch self/bus power by itself; 0 never.
// - with auto power on, supply presence comes from the local supply pin.
// - a supply change at once disconnects downstream and removes port power.
// - the same supply change also drops the upstream connection.
// - reattach bus-powered without supply, self-powered with supply.
// - delay select 00/01/10/11 gives 0.1/4/8/16 ms over-current delay.
// - compound bit reports whether hub is part of a compound device.
// - strap config reports compound whenever any port is non-removable.
// - numbering select 0 is standard mode, 1 is port mapping mode.
// - string enable bit turns string descriptor support off or on.
// - fixed mask bits 1-4 mark ports 1-4 non-removable; others reserved.
// - in strap config the fixed ports come from the two strap pins.
// - with auto power on, configured self/bus bit is ignored.
// - standard mode disables masked ports and reports the enabled count.
module hpc_port_cfg_regs
  import hpc_pkg::*;
#(
  parameter int unsigned OC_DELAY0_CYCLES = OC_CYC0,
  parameter int unsigned OC_DELAY1_CYCLES = OC_CYC1,
  parameter int unsigned OC_DELAY2_CYCLES = OC_CYC2,
  parameter int unsigned OC_DELAY3_CYCLES = OC_CYC3
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  output logic [7:0] cfgRdData,
  output logic cfgRdValid,
  input wire logic strapConfigPin,
  input wire logic [1:0] fixed_port_strap_pins,
  input wire logic local_supply_present,
  input wire logic selfPoweredCfg,
  input wire logic [4:1] portDisableMask,
  output logic upstreamConnect,
  output logic portPowerOn,
  output logic selfPowered,
  output logic [OC_CNT_W-1:0] ocDelayCycles,
  output logic compoundReport,
  output logic [4:1] fixedPorts,
  output logic portMappingMode,
  output logic stringEnable,
  output logic [4:1] activePorts,
  output logic [2:0] enabledPortCount
);

  // ********************************************************************
  // pin synchronisers
  // ********************************************************************
  logic [3:0] pinSync;
  logic supplySync;
  logic strapMode;
  logic [1:0] strapFixed;

  hpc_sync2 #(.W(4)) pinSyncInst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .asyncIn({local_supply_present, strapConfigPin, fixed_port_strap_pins}),
    .syncOut(pinSync)
  );

  assign supplySync = pinSync[3];
  assign strapMode = pinSync[2];
  assign strapFixed = pinSync[1:0];

  // ********************************************************************
  // configuration registers
  // ********************************************************************
  logic [7:0] power_and_device_config_reg;
  logic [7:0] port_numbering_config_reg;
  logic [7:0] fixed_device_port_mask_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      power_and_device_config_reg <= PWR_DEV_RST;
      port_numbering_config_reg <= PORT_NUM_RST;
      fixed_device_port_mask_reg <= FIXED_MASK_RST;
    end
    else if (clkEn && cfgWrEn)
    begin
      case (cfgAddr)
        PWR_DEV_CFG_OFS: power_and_device_config_reg <= cfgWrData & PWR_DEV_WR_MASK;
        PORT_NUM_CFG_OFS: port_numbering_config_reg <= cfgWrData & PORT_NUM_WR_MASK;
        FIXED_MASK_OFS: fixed_device_port_mask_reg <= cfgWrData & FIXED_MASK_WR_MASK;
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cfgRdData <= 8'h00;
      cfgRdValid <= 1'b0;
    end
    else if (clkEn)
    begin
      cfgRdValid <= cfgRdEn;
      if (cfgRdEn)
      begin
        case (cfgAddr)
          PWR_DEV_CFG_OFS: cfgRdData <= power_and_device_config_reg;
          PORT_NUM_CFG_OFS: cfgRdData <= port_numbering_config_reg;
          FIXED_MASK_OFS: cfgRdData <= fixed_device_port_mask_reg;
          default: cfgRdData <= 8'h00;
        endcase
      end
    end
  end

  reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfgRdValid |-> (cfgRdData & ~(PWR_DEV_WR_MASK | PORT_NUM_WR_MASK | FIXED_MASK_WR_MASK)) == 8'h00)
    else $error("reserved bits read nonzero");

  logic autoEn;
  logic [1:0] ocSel;
  assign autoEn = power_and_device_config_reg[AUTO_PWR_BIT];
  assign ocSel = power_and_device_config_reg[OC_SEL_LSB +: 2];

  // ********************************************************************
  // automatic power switching
  // ********************************************************************
  hpc_state_type stateReg;
  hpc_state_type stateNext;
  logic supplyLastReg;
  logic [4:0] dropCntReg;
  logic supplyChanged;

  assign supplyChanged = autoEn && (supplySync != supplyLastReg);

  always_comb
  begin
    stateNext = stateReg;
    case (stateReg)
      ST_RUN: if (supplyChanged) stateNext = ST_DROP;
      ST_DROP: if (dropCntReg == DROP_CYCLES) stateNext = ST_REATTACH;
      ST_REATTACH: stateNext = ST_RUN;
      default: stateNext = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      stateReg <= ST_RUN;
    else if (clkEn)
      stateReg <= stateNext;
  end

  // long enough that the upstream side sees a real detach
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      dropCntReg <= 5'h00;
    else if (clkEn)
      dropCntReg <= (stateReg == ST_DROP) ? dropCntReg + 5'h01 : 5'h00;
  end

  // with auto off the last level just tracks, so enabling never causes a false drop
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      supplyLastReg <= 1'b0;
    else if (clkEn && (!autoEn || stateReg == ST_RUN))
      supplyLastReg <= supplySync;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      upstreamConnect <= 1'b0;
      portPowerOn <= 1'b0;
      selfPowered <= 1'b0;
    end
    else if (clkEn)
    begin
      upstreamConnect <= (stateNext == ST_RUN);
      portPowerOn <= (stateNext == ST_RUN);
      selfPowered <= autoEn ? supplyLastReg : selfPoweredCfg;
    end
  end

  drop_on_change_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && stateReg == ST_RUN && supplyChanged) |=> (!upstreamConnect && !portPowerOn))
    else $error("no shutdown after supply change");

  no_auto_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (stateReg == ST_RUN && !autoEn) |=> stateReg == ST_RUN)
    else $error("switching with auto power off");

  reattach_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && stateReg == ST_DROP) [*2] |-> !upstreamConnect ##[1:40] upstreamConnect)
    else $error("upstream not reattached");

  power_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && autoEn) |=> selfPowered == $past(supplyLastReg))
    else $error("power mode not from supply");

  // ********************************************************************
  // derived configuration outputs
  // ********************************************************************
  logic [OC_CNT_W-1:0] ocExpect;
  logic [4:1] fixedNext;
  logic [2:0] disabledCount;

  always_comb
  begin
    case (ocSel)
      2'b00: ocExpect = OC_CNT_W'(OC_DELAY0_CYCLES);
      2'b01: ocExpect = OC_CNT_W'(OC_DELAY1_CYCLES);
      2'b10: ocExpect = OC_CNT_W'(OC_DELAY2_CYCLES);
      2'b11: ocExpect = OC_CNT_W'(OC_DELAY3_CYCLES);
      default: ocExpect = OC_CNT_W'(OC_DELAY0_CYCLES);
    endcase
  end

  // strap code n marks ports 1..n as fixed
  always_comb
  begin
    if (strapMode)
    begin
      case (strapFixed)
        2'b00: fixedNext = 4'h0;
        2'b01: fixedNext = 4'h1;
        2'b10: fixedNext = 4'h3;
        2'b11: fixedNext = 4'h7;
        default: fixedNext = 4'h0;
      endcase
    end
    else
      fixedNext = fixed_device_port_mask_reg[FIXED_PORT_LSB +: 4];
  end

  assign disabledCount = {2'b00, portDisableMask[1]} + {2'b00, portDisableMask[2]}
    + {2'b00, portDisableMask[3]} + {2'b00, portDisableMask[4]};

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ocDelayCycles <= OC_CNT_W'(OC_DELAY0_CYCLES);
      fixedPorts <= 4'h0;
      compoundReport <= 1'b0;
      portMappingMode <= 1'b0;
      stringEnable <= 1'b0;
      activePorts <= 4'hf;
      enabledPortCount <= 3'h4;
    end
    else if (clkEn)
    begin
      ocDelayCycles <= ocExpect;
      fixedPorts <= fixedNext;
      compoundReport <= strapMode ? (|fixedNext)
        : power_and_device_config_reg[COMPOUND_BIT];
      portMappingMode <= port_numbering_config_reg[PORT_NUM_SEL_BIT];
      stringEnable <= port_numbering_config_reg[STRING_EN_BIT];
      // mapping mode owns port enables elsewhere, so only standard mode masks here
      activePorts <= port_numbering_config_reg[PORT_NUM_SEL_BIT] ? 4'hf
        : ~portDisableMask;
      enabledPortCount <= port_numbering_config_reg[PORT_NUM_SEL_BIT] ? 3'h4
        : 3'h4 - disabledCount;
    end
  end

  oc_delay_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && ocSel == 2'b11) |=> ocDelayCycles == OC_CNT_W'(OC_DELAY3_CYCLES))
    else $error("wrong over-current delay");

  compound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && strapMode && strapFixed != 2'b00) |=> compoundReport)
    else $error("strap fixed port without compound");

  compound_bit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && !strapMode) |=> compoundReport == $past(power_and_device_config_reg[COMPOUND_BIT]))
    else $error("compound not from register");

  port_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && !portMappingMode && port_numbering_config_reg == 8'h00)
      |=> enabledPortCount == 3'h4 - $past(disabledCount))
    else $error("enabled port count wrong");

  strap_ports_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clkEn && strapMode && strapFixed == 2'b10) |=> fixedPorts == 4'h3)
    else $error("strap ports not applied");

endmodule
`default_nettype wire

/* File: verification/hpc_cfg_source.sv */
// config source model: loader that writes and reads single bytes
// assumes the bank samples its strobes on rising core_clk
`timescale 1ns/100ps
`default_nettype none
module hpc_cfg_source
  import hpc_pkg::*;
(
  input wire logic core_clk,
  output logic cfgWrEn,
  output logic cfgRdEn,
  output logic [7:0] cfgAddr,
  output logic [7:0] cfgWrData,
  input wire logic [7:0] cfgRdData,
  input wire logic cfgRdValid
);
  initial
  begin
    cfgWrEn = 1'b0;
    cfgRdEn = 1'b0;
    cfgAddr = 8'h00;
    cfgWrData = 8'h00;
  end
  // ******************************************************************
  // byte transfers
  // ******************************************************************
  // idle bus shows inverted values so stale data never passes for fresh
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cfgWrEn <= 1'b1;
    cfgAddr <= a;
    cfgWrData <= d;
    @(posedge core_clk);
    cfgWrEn <= 1'b0;
    cfgAddr <= ~a;
    cfgWrData <= ~d;
  endtask
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge core_clk);
    cfgRdEn <= 1'b1;
    cfgAddr <= a;
    @(posedge core_clk);
    cfgRdEn <= 1'b0;
    cfgAddr <= ~a;
    #1;
    d = cfgRdData;
    v = cfgRdValid;
  endtask
  // compound flag never goes out without a fixed port
  task automatic load_compound(input logic [7:0] b07, input logic [7:0] b09);
    wr_byte(PWR_DEV_CFG_OFS, b07 | 8'h08);
    wr_byte(FIXED_MASK_OFS, b09 | 8'h02);
  endtask
endmodule
`default_nettype wire

/* File: verification/hub_power_port_config_regs_tb.sv */
// self-checking bench for the power and port configuration bank
// assumes hpc_cfg_source as loader; pins driven directly by the bench
`timescale 1ns/100ps
`default_nettype none
module hub_power_port_config_regs_tb;
  import hpc_pkg::*;
  logic core_clk, rst_n, clkEn, strapConfigPin, local_supply_present, selfPoweredCfg;
  logic cfgWrEn, cfgRdEn, cfgRdValid, upstreamConnect, portPowerOn, selfPowered;
  logic compoundReport, portMappingMode, stringEnable, v, lvl;
  logic [7:0] cfgAddr, cfgWrData, cfgRdData, b, d;
  logic [1:0] fixed_port_strap_pins;
  logic [4:1] portDisableMask, fixedPorts, activePorts;
  logic [20:0] ocDelayCycles;
  logic [2:0] enabledPortCount;
  int errCount, nChecks, drops;
  hpc_cfg_source src (.core_clk(core_clk), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
    .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid));
  // short delays keep the run brief; only the reported count changes
  hpc_port_cfg_regs #(.OC_DELAY0_CYCLES(10), .OC_DELAY1_CYCLES(40), .OC_DELAY2_CYCLES(80),
    .OC_DELAY3_CYCLES(160)) dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .strapConfigPin(strapConfigPin),
    .fixed_port_strap_pins(fixed_port_strap_pins), .local_supply_present(local_supply_present),
    .selfPoweredCfg(selfPoweredCfg), .portDisableMask(portDisableMask),
    .upstreamConnect(upstreamConnect), .portPowerOn(portPowerOn), .selfPowered(selfPowered),
    .ocDelayCycles(ocDelayCycles), .compoundReport(compoundReport), .fixedPorts(fixedPorts),
    .portMappingMode(portMappingMode), .stringEnable(stringEnable), .activePorts(activePorts),
    .enabledPortCount(enabledPortCount));
  // ******************************************************************
  // expectations and checks
  // ******************************************************************
  function automatic logic [20:0] exp_oc(input logic [1:0] c);
    return (c == 2'h0) ? 21'h00000a : (c == 2'h1) ? 21'h000028 :
      (c == 2'h2) ? 21'h000050 : 21'h0000a0;
  endfunction
  function automatic logic [4:1] exp_strap(input logic [1:0] c);
    return 4'((5'h01 << c) - 5'h01);
  endfunction
  function automatic logic [2:0] count_on(input logic [4:1] m);
    return 3'(m[1]) + 3'(m[2]) + 3'(m[3]) + 3'(m[4]);
  endfunction
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("mismatch at %0t: output %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_rw(input logic [7:0] a, input logic [7:0] wd, input logic [7:0] m);
    src.wr_byte(a, wd);
    src.rd_byte(a, d, v);
    chk_reg(d, wd & m);
    chk_out(32'(v), 32'h1);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_up(input logic want, input int lim);
    for (int j = 0; j < lim && upstreamConnect !== want; j++) settle(1);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ******************************************************************
  // clock, watchdog and tests
  // ******************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    #200000;
    errCount++;
    $display("watchdog expired");
    print_verdict();
  end
  initial
  begin
    {rst_n, strapConfigPin, local_supply_present, selfPoweredCfg} = 4'h0;
    clkEn = 1'b1;
    fixed_port_strap_pins = 2'h0;
    portDisableMask = 4'h0;
    errCount = 0;
    nChecks = 0;
    void'($urandom(29940));
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    settle(2);
    chk_out(32'(upstreamConnect), 32'h1);
    chk_out(32'(ocDelayCycles), 32'(exp_oc(2'h0)));
    for (int i = 7; i < 10; i++)
    begin
      src.rd_byte(8'(i), d, v);
      chk_reg(d, 8'h00);
    end
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      b = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      reg_rw(PWR_DEV_CFG_OFS, b & 8'h7f, 8'hb8);
      reg_rw(PORT_NUM_CFG_OFS, ~b, 8'h09);
      reg_rw(FIXED_MASK_OFS, b, 8'h1e);
      reg_rw(8'h0a, b, 8'h00);
      settle(2);
      chk_out(32'(ocDelayCycles), 32'(exp_oc(b[5:4])));
      chk_out(32'(compoundReport), 32'(b[3]));
      chk_out(32'(portMappingMode), 32'(!b[3]));
      chk_out(32'(stringEnable), 32'(!b[0]));
      chk_out(32'(fixedPorts), 32'(b[4:1]));
    end
    $display("test fields done");
    src.wr_byte(PORT_NUM_CFG_OFS, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk);
      portDisableMask <= (i == 0) ? 4'hf : 4'($urandom);
      settle(3);
      chk_out(32'(activePorts), 32'(4'(~portDisableMask)));
      chk_out(32'(enabledPortCount), 32'(count_on(~portDisableMask)));
    end
    src.wr_byte(PORT_NUM_CFG_OFS, 8'h08);
    settle(2);
    chk_out(32'(activePorts), 32'hf);
    chk_out(32'(enabledPortCount), 32'h4);
    $display("test numbering done");
    src.wr_byte(PWR_DEV_CFG_OFS, 8'h00);
    src.wr_byte(FIXED_MASK_OFS, 8'h00);
    @(posedge core_clk);
    strapConfigPin <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      @(posedge core_clk);
      fixed_port_strap_pins <= 2'(c);
      settle(5);
      chk_out(32'(fixedPorts), 32'(exp_strap(2'(c))));
      chk_out(32'(compoundReport), 32'(c != 0));
    end
    @(posedge core_clk);
    strapConfigPin <= 1'b0;
    src.load_compound(8'h00, 8'h04);
    settle(5);
    chk_out(32'(compoundReport), 32'h1);
    chk_out(32'(fixedPorts), 32'h3);
    $display("test strap done");
    src.wr_byte(PWR_DEV_CFG_OFS, 8'h00);
    selfPoweredCfg <= 1'b1;
    local_supply_present <= 1'b1;
    drops = 0;
    repeat (30)
    begin
      settle(1);
      drops += int'(upstreamConnect !== 1'b1);
    end
    chk_out(32'(drops), 32'h0);
    chk_out(32'(selfPowered), 32'h1);
    src.wr_byte(PWR_DEV_CFG_OFS, 8'h80);
    selfPoweredCfg <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      lvl = 1'(k);
      @(posedge core_clk);
      local_supply_present <= lvl;
      selfPoweredCfg <= ~lvl;
      wait_up(1'b0, 10);
      chk_out(32'(upstreamConnect), 32'h0);
      chk_out(32'(portPowerOn), 32'h0);
      wait_up(1'b1, 40);
      chk_out(32'(upstreamConnect), 32'h1);
      chk_out(32'(selfPowered), 32'(lvl));
    end
    $display("test power done");
    // frozen clock enable: the write is lost and outputs hold
    @(posedge core_clk);
    clkEn <= 1'b0;
    src.wr_byte(FIXED_MASK_OFS, 8'h1e);
    settle(2);
    chk_out(32'(fixedPorts), 32'h3);
    @(posedge core_clk);
    clkEn <= 1'b1;
    src.rd_byte(FIXED_MASK_OFS, d, v);
    chk_reg(d, 8'h06);
    $display("test enable done");
    print_verdict();
  end
endmodule
`default_nettype wire
